// [hdl/sleep_and_reset_control.sv]
// sleep mode sequencer, peripheral clock stops and reset source combiner
// What this block does
// - mode field bits 3:1 picks sleep mode
// - sleep instruction sleeps only when armed
// - converter stop bit gates converter clock
// - stopped converter blocks comparator input mux
// - timer stop bit freezes timer, resumes intact
// - any reset forces sleep and clock stop registers to initial values
// - port pins reset asynchronously on power-on or external pin, no clock
// - delay counter stretches reset after sources
// - power-on asserts reset at once, launches delay
// - external pin resets ports without clock, then delay
// - disable fuse makes external pin ignored
// - watchdog expiry resets only in reset mode
// - watchdog reset pulse one cycle, starts delay
// - low-supply flag set when below level
// - enabled flag raises low-supply interrupt
// - flag clears by write, level change, recovery
// - low supply gives interrupt or reset
// - supply reset held while low, then startup
// - supply cause flag set while supply reset held
// - wake halts core four cycles past startup
// - stopped peripheral frozen, registers inaccessible
// - power-down gates all generated clocks
// - standby as power-down but oscillator runs
//
// Chosen here: the plain strobed port.
module sleep_and_reset_control #(
  parameter int unsigned STARTUP_CYCLES = sleep_reset_pkg::STARTUP_DELAY_CYCLES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ext_reset_pin_n,
  input wire logic external_reset_disable_fuse,
  input wire logic supply_below_level,
  input wire logic wdt_timeout,
  input wire logic wdt_reset_mode,
  input wire logic sleep_instr,
  input wire logic wake_event,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic core_reset,
  output logic io_port_reset,
  output logic cpu_clk_en,
  output logic io_clk_en,
  output logic timer_clk_en,
  output logic adc_clk_en,
  output logic osc_en,
  output logic comparator_mux_allowed,
  output logic adc_reg_access_en,
  output logic timer_reg_access_en,
  output logic [2:0] supply_trigger_level,
  output logic supply_low_irq
);

  // synchroniser lanes
  localparam int SY_EXT = 0;
  localparam int SY_SUPPLY = 1;
  localparam int SY_FUSE = 2;
  localparam logic [2:0] SYNC_RST = 3'h1;

  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic supply_prev;
    logic wdt_prev;
    logic wdt_pulse;
    logic [7:0] sleep_mode_ctrl;
    logic [7:0] power_reduction_ctrl;
    logic [7:0] supply_monitor_ctrl_status;
    logic [3:0] reset_cause;
    logic [7:0] rdata;
    sleep_reset_pkg::sleep_state_t state;
    logic [2:0] active_mode;
    logic [sleep_reset_pkg::WAKE_CNT_W-1:0] wake_cnt;
  } ctrl_state_t;

  ctrl_state_t st_r;
  ctrl_state_t st_nxt;

  logic startup_done;
  logic ext_active;
  logic supply_below;
  logic supply_rst;
  logic any_src;
  logic supply_low_flag;
  logic [2:0] sleep_mode_select;
  logic [2:0] clk_on;

  // a sleep request with any unlisted code is dropped
  function automatic logic mode_valid(input logic [2:0] m);
    return (m == sleep_reset_pkg::MODE_IDLE) || (m == sleep_reset_pkg::MODE_CONV_NR) ||
      (m == sleep_reset_pkg::MODE_POWER_DOWN) || (m == sleep_reset_pkg::MODE_STANDBY);
  endfunction

  // clocks per mode as {osc, converter, io}; cpu handled apart
  function automatic logic [2:0] mode_clocks(input logic [2:0] m);
    case (m)
      sleep_reset_pkg::MODE_IDLE: mode_clocks = 3'h7;
      sleep_reset_pkg::MODE_CONV_NR: mode_clocks = 3'h6;
      sleep_reset_pkg::MODE_STANDBY: mode_clocks = 3'h4;
      default: mode_clocks = 3'h0;
    endcase
  endfunction

  // decoded sources, pin, fuse and supply taken from the second synchroniser stage
  assign ext_active = !st_r.sync2[SY_EXT] && !st_r.sync2[SY_FUSE];
  assign supply_below = st_r.sync2[SY_SUPPLY];
  assign supply_rst = supply_below &&
    st_r.supply_monitor_ctrl_status[sleep_reset_pkg::RST_EN_BIT];
  assign any_src = ext_active || supply_rst || st_r.wdt_pulse;
  assign supply_low_flag = st_r.supply_monitor_ctrl_status[sleep_reset_pkg::LOW_FLAG_BIT];
  assign sleep_mode_select =
    st_r.sleep_mode_ctrl[sleep_reset_pkg::MODE_MSB:sleep_reset_pkg::MODE_LSB];

  // reset stretch: restarts while a source holds, runs after all go away
  startup_delay_counter #(
    .CYCLES(STARTUP_CYCLES)
  ) u_startup (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .hold(any_src),
    .expired(startup_done)
  );

  // next-state logic for registers, flags and sleep sequencer
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = {external_reset_disable_fuse, supply_below_level, ext_reset_pin_n};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.supply_prev = supply_below;
    st_nxt.wdt_prev = wdt_timeout;
    // one-cycle pulse per expiry, only in system reset mode
    st_nxt.wdt_pulse = wdt_timeout && !st_r.wdt_prev && wdt_reset_mode;
    st_nxt.rdata = 8'h00;

    // reset cause bits: software writes zero, hardware set wins
    if (reg_wr && reg_addr == sleep_reset_pkg::OFS_RESET_CAUSE) begin
      st_nxt.reset_cause = st_r.reset_cause & reg_wdata[3:0];
    end
    if (ext_active) begin
      st_nxt.reset_cause[sleep_reset_pkg::CAUSE_EXT_BIT] = 1'b1;
    end
    if (supply_rst) begin
      st_nxt.reset_cause[sleep_reset_pkg::CAUSE_SUPPLY_BIT] = 1'b1;
    end
    if (st_r.wdt_pulse) begin
      st_nxt.reset_cause[sleep_reset_pkg::CAUSE_WDT_BIT] = 1'b1;
    end

    // supply monitor control; kept through non-power-on resets so a
    // supply reset cannot wipe out its own enable
    if (reg_wr && reg_addr == sleep_reset_pkg::OFS_SUPPLY_MON) begin
      st_nxt.supply_monitor_ctrl_status[4:0] = reg_wdata[4:0] &
        sleep_reset_pkg::SUPPLY_WR_MASK[4:0];
      if (!reg_wdata[sleep_reset_pkg::LOW_FLAG_BIT] ||
          reg_wdata[2:0] != st_r.supply_monitor_ctrl_status[2:0]) begin
        st_nxt.supply_monitor_ctrl_status[sleep_reset_pkg::LOW_FLAG_BIT] = 1'b0;
      end
    end
    if (!supply_below) begin
      st_nxt.supply_monitor_ctrl_status[sleep_reset_pkg::LOW_FLAG_BIT] = 1'b0;
    end else if (!st_r.supply_prev) begin
      // fresh drop sets the flag even against a clearing write
      st_nxt.supply_monitor_ctrl_status[sleep_reset_pkg::LOW_FLAG_BIT] = 1'b1;
    end

    // register reads, answer one cycle later
    if (reg_rd) begin
      case (reg_addr)
        sleep_reset_pkg::OFS_SLEEP_MODE: st_nxt.rdata = st_r.sleep_mode_ctrl;
        sleep_reset_pkg::OFS_POWER_REDUCTION: st_nxt.rdata = st_r.power_reduction_ctrl;
        sleep_reset_pkg::OFS_SUPPLY_MON: st_nxt.rdata = st_r.supply_monitor_ctrl_status;
        sleep_reset_pkg::OFS_RESET_CAUSE: st_nxt.rdata = {4'h0, st_r.reset_cause};
        default: st_nxt.rdata = 8'h00;
      endcase
    end

    // control register writes
    if (reg_wr && reg_addr == sleep_reset_pkg::OFS_SLEEP_MODE) begin
      st_nxt.sleep_mode_ctrl = reg_wdata & sleep_reset_pkg::SLEEP_MODE_MASK;
    end
    if (reg_wr && reg_addr == sleep_reset_pkg::OFS_POWER_REDUCTION) begin
      st_nxt.power_reduction_ctrl = reg_wdata & sleep_reset_pkg::POWER_REDUCTION_MASK;
    end

    // sleep sequencer
    case (st_r.state)
      sleep_reset_pkg::ST_ACTIVE: begin
        if (sleep_instr && st_r.sleep_mode_ctrl[sleep_reset_pkg::SLEEP_ARM_BIT] &&
            mode_valid(sleep_mode_select)) begin
          st_nxt.state = sleep_reset_pkg::ST_SLEEP;
          st_nxt.active_mode = sleep_mode_select;
        end
      end
      sleep_reset_pkg::ST_SLEEP: begin
        if (wake_event) begin
          st_nxt.state = sleep_reset_pkg::ST_WAKE;
          // oscillator restart only when it was stopped
          if (st_r.active_mode == sleep_reset_pkg::MODE_POWER_DOWN) begin
            st_nxt.wake_cnt = sleep_reset_pkg::WAKE_CNT_W'(sleep_reset_pkg::OSC_START_CYCLES +
              sleep_reset_pkg::WAKE_HALT_CYCLES - 1);
          end else begin
            st_nxt.wake_cnt =
              sleep_reset_pkg::WAKE_CNT_W'(sleep_reset_pkg::WAKE_HALT_CYCLES - 1);
          end
        end
      end
      sleep_reset_pkg::ST_WAKE: begin
        if (st_r.wake_cnt == '0) begin
          st_nxt.state = sleep_reset_pkg::ST_ACTIVE;
        end else begin
          st_nxt.wake_cnt = st_r.wake_cnt - sleep_reset_pkg::WAKE_CNT_W'(1);
        end
      end
      default: st_nxt.state = sleep_reset_pkg::ST_ACTIVE;
    endcase

    // any reset in force puts sleep and power-reduction state back to initial values
    if (any_src || !startup_done) begin
      st_nxt.sleep_mode_ctrl = sleep_reset_pkg::RST_SLEEP_MODE;
      st_nxt.power_reduction_ctrl = sleep_reset_pkg::RST_POWER_REDUCTION;
      st_nxt.state = sleep_reset_pkg::ST_ACTIVE;
      st_nxt.active_mode = sleep_reset_pkg::MODE_IDLE;
      st_nxt.wake_cnt = '0;
    end
  end

  // power-on detect clears everything at once and marks the cause
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.sync1 <= SYNC_RST;
      st_r.sync2 <= SYNC_RST;
      st_r.sleep_mode_ctrl <= sleep_reset_pkg::RST_SLEEP_MODE;
      st_r.power_reduction_ctrl <= sleep_reset_pkg::RST_POWER_REDUCTION;
      st_r.supply_monitor_ctrl_status <= sleep_reset_pkg::RST_SUPPLY_MON;
      st_r.reset_cause <= sleep_reset_pkg::RST_RESET_CAUSE;
      st_r.state <= sleep_reset_pkg::ST_ACTIVE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // core held until the delay runs out; nrst drops it with no clock
  assign core_reset = !startup_done;

  // ports need no clock; raw pin used on purpose, a synchroniser
  // would need the very clock that may be stopped
  assign io_port_reset = !nrst || (!ext_reset_pin_n && !external_reset_disable_fuse) ||
    core_reset;

  // clock enables per sleep state
  always_comb begin
    if (st_r.state == sleep_reset_pkg::ST_SLEEP) begin
      clk_on = mode_clocks(st_r.active_mode);
    end else begin
      clk_on = 3'h7;
    end
  end

  assign cpu_clk_en = (st_r.state == sleep_reset_pkg::ST_ACTIVE) && !core_reset;
  assign io_clk_en = clk_on[0];
  assign osc_en = clk_on[2];
  // gating the clock keeps timer state intact across the stop
  assign timer_clk_en = clk_on[0] &&
    !st_r.power_reduction_ctrl[sleep_reset_pkg::TIMER_STOP_BIT];
  assign adc_clk_en = clk_on[1] &&
    !st_r.power_reduction_ctrl[sleep_reset_pkg::CONVERTER_STOP_BIT];
  assign comparator_mux_allowed =
    !st_r.power_reduction_ctrl[sleep_reset_pkg::CONVERTER_STOP_BIT];
  assign adc_reg_access_en =
    !st_r.power_reduction_ctrl[sleep_reset_pkg::CONVERTER_STOP_BIT];
  assign timer_reg_access_en =
    !st_r.power_reduction_ctrl[sleep_reset_pkg::TIMER_STOP_BIT];
  assign supply_trigger_level =
    st_r.supply_monitor_ctrl_status[sleep_reset_pkg::LEVEL_MSB:sleep_reset_pkg::LEVEL_LSB];
  // in reset configuration low supply resets instead of interrupting
  assign supply_low_irq = supply_low_flag &&
    st_r.supply_monitor_ctrl_status[sleep_reset_pkg::IRQ_EN_BIT] &&
    !st_r.supply_monitor_ctrl_status[sleep_reset_pkg::RST_EN_BIT];
  assign reg_rdata = st_r.rdata;

  // checks on the sequencer, clock stops, watchdog pulse, reset stretch and low-supply flag
  AST_RESERVED_NOP: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_r.state == sleep_reset_pkg::ST_ACTIVE && sleep_instr && !mode_valid(sleep_mode_select))
    |=> st_r.state == sleep_reset_pkg::ST_ACTIVE)
    else $error("sleep entered on reserved mode code");

  AST_ARM_NEEDED: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_r.state == sleep_reset_pkg::ST_ACTIVE &&
     !st_r.sleep_mode_ctrl[sleep_reset_pkg::SLEEP_ARM_BIT])
    |=> st_r.state != sleep_reset_pkg::ST_SLEEP)
    else $error("sleep entered without arm bit");

  AST_WAKE_HALT: assert property (@(posedge sys_clk) disable iff (!nrst || any_src)
    (st_r.state == sleep_reset_pkg::ST_SLEEP && wake_event &&
     st_r.active_mode == sleep_reset_pkg::MODE_IDLE && startup_done)
    |=> (!cpu_clk_en) [*4] ##1 cpu_clk_en)
    else $error("wake halt not four cycles");

  AST_POWER_DOWN_GATED: assert property (@(posedge sys_clk) disable iff (!nrst)
    (st_r.state == sleep_reset_pkg::ST_SLEEP &&
     st_r.active_mode == sleep_reset_pkg::MODE_POWER_DOWN)
    |-> !osc_en && !io_clk_en && !adc_clk_en && !cpu_clk_en)
    else $error("clock running in power-down");

  AST_CONVERTER_STOP: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(st_r.power_reduction_ctrl[sleep_reset_pkg::CONVERTER_STOP_BIT])
    |-> !adc_clk_en && !comparator_mux_allowed && !adc_reg_access_en)
    else $error("converter still clocked after stop");

  AST_TIMER_STOP: assert property (@(posedge sys_clk) disable iff (!nrst)
    (reg_wr && reg_addr == sleep_reset_pkg::OFS_POWER_REDUCTION &&
     reg_wdata[sleep_reset_pkg::TIMER_STOP_BIT] && !any_src && startup_done)
    |=> !timer_clk_en && !timer_reg_access_en)
    else $error("timer clock not stopped");

  AST_WDT_PULSE: assert property (@(posedge sys_clk) disable iff (!nrst)
    st_r.wdt_pulse |=> !st_r.wdt_pulse ##0 core_reset)
    else $error("watchdog pulse wrong");

  AST_WDT_MODE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (wdt_timeout && !wdt_reset_mode) |=> !st_r.wdt_pulse)
    else $error("watchdog reset outside reset mode");

  AST_RESET_STRETCH: assert property (@(posedge sys_clk) disable iff (!nrst)
    (any_src ##1 !any_src) |-> core_reset [*2])
    else $error("internal reset not stretched");

  AST_FLAG_CLEAR: assert property (@(posedge sys_clk) disable iff (!nrst)
    !supply_below |=> !supply_low_flag)
    else $error("low-supply flag kept after recovery");

  // a fresh drop with the interrupt configured must reach the request line
  AST_IRQ: assert property (@(posedge sys_clk) disable iff (!nrst)
    (supply_below && !$past(supply_below) && !reg_wr &&
     st_r.supply_monitor_ctrl_status[sleep_reset_pkg::IRQ_EN_BIT] &&
     !st_r.supply_monitor_ctrl_status[sleep_reset_pkg::RST_EN_BIT])
    |=> supply_low_irq)
    else $error("low supply drop raised no interrupt");

endmodule

// [hdl/sleep_reset_pkg.sv]
// shared constants for the sleep and reset controller
package sleep_reset_pkg;

  // register offsets on the i/o register port
  localparam logic [5:0] OFS_POWER_REDUCTION = 6'h35;
  localparam logic [5:0] OFS_SLEEP_MODE = 6'h3a;
  localparam logic [5:0] OFS_SUPPLY_MON = 6'h34;
  localparam logic [5:0] OFS_RESET_CAUSE = 6'h3b;

  // reset values
  localparam logic [7:0] RST_POWER_REDUCTION = 8'h00;
  localparam logic [7:0] RST_SLEEP_MODE = 8'h00;
  localparam logic [7:0] RST_SUPPLY_MON = 8'h00;
  localparam logic [3:0] RST_RESET_CAUSE = 4'h1;

  // sleep_mode_ctrl fields
  localparam int SLEEP_ARM_BIT = 0;
  localparam int MODE_LSB = 1;
  localparam int MODE_MSB = 3;
  localparam logic [7:0] SLEEP_MODE_MASK = 8'h0f;

  // power_reduction_ctrl fields
  localparam int TIMER_STOP_BIT = 0;
  localparam int CONVERTER_STOP_BIT = 1;
  localparam logic [7:0] POWER_REDUCTION_MASK = 8'h03;

  // supply_monitor_ctrl_status fields
  localparam int LEVEL_LSB = 0;
  localparam int LEVEL_MSB = 2;
  localparam int IRQ_EN_BIT = 3;
  localparam int RST_EN_BIT = 4;
  localparam int LOW_FLAG_BIT = 7;
  localparam logic [7:0] SUPPLY_WR_MASK = 8'h1f;

  // reset cause fields
  localparam int CAUSE_POR_BIT = 0;
  localparam int CAUSE_EXT_BIT = 1;
  localparam int CAUSE_SUPPLY_BIT = 2;
  localparam int CAUSE_WDT_BIT = 3;

  // sleep mode codes
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_CONV_NR = 3'h1;
  localparam logic [2:0] MODE_POWER_DOWN = 3'h2;
  localparam logic [2:0] MODE_STANDBY = 3'h4;

  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int STARTUP_DELAY_NS = 64000;
  localparam int STARTUP_DELAY_CYCLES = (STARTUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_START_NS = 1000;
  localparam int OSC_START_CYCLES = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_HALT_CYCLES = 4;
  localparam int WAKE_CNT_W = 8;

  // sleep sequencer states
  typedef enum logic [1:0] {ST_ACTIVE, ST_SLEEP, ST_WAKE} sleep_state_t;

endpackage

// [hdl/startup_delay_counter.sv]
// start-up delay counter that stretches the internal reset
module startup_delay_counter #(
  parameter int unsigned CYCLES = 3200,
  parameter int W = $clog2(CYCLES + 1)
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic hold,
  output logic expired
);

  typedef struct packed {
    logic [W-1:0] count;
    logic done;
  } cnt_state_t;

  cnt_state_t st_r;
  cnt_state_t st_nxt;

  // restart from zero while any source holds, count up once all are gone
  always_comb begin
    st_nxt = st_r;
    if (hold) begin
      st_nxt.count = '0;
      st_nxt.done = 1'b0;
    end else if (!st_r.done) begin
      if (st_r.count == W'(CYCLES - 1)) begin
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.count = st_r.count + W'(1);
      end
    end
  end

  // power-on drops the done bit at once, no clock needed
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign expired = st_r.done;

endmodule

// [test/core_model.sv]
// processor core model: i/o register master, sleep instruction and wake source
module core_model (
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  output logic [5:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic sleep_instr,
  output logic wake_event
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial begin
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sleep_instr = 1'b0;
    wake_event = 1'b0;
  end

  // one-cycle write; released lines show the inverse so stale values cannot pass
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // one-cycle read; data taken in the following cycle only
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask

  // arm right before sleeping, so a stray instruction elsewhere cannot sleep
  task automatic sleep_go(input logic [2:0] mode, input logic arm);
    wr(sleep_reset_pkg::OFS_SLEEP_MODE, {4'h0, mode, arm});
    @(posedge sys_clk);
    sleep_instr <= 1'b1;
    @(posedge sys_clk);
    sleep_instr <= 1'b0;
  endtask

  // disarm straight after wake-up
  task automatic disarm;
    wr(sleep_reset_pkg::OFS_SLEEP_MODE, 8'h00);
  endtask

  // converter has no enable in this model, so it is always idle before the stop
  task automatic stop_converter;
    wr(sleep_reset_pkg::OFS_POWER_REDUCTION, 8'h02);
  endtask

  // one-cycle wake request from an enabled interrupt
  task automatic wake;
    @(posedge sys_clk);
    wake_event <= 1'b1;
    @(posedge sys_clk);
    wake_event <= 1'b0;
  endtask
endmodule

// [test/sleep_and_reset_control_bench.sv]
// self-checking bench for the sleep and reset controller
module sleep_and_reset_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SU = 8;
  localparam int CR = 1;
  localparam int CPU = 2;
  localparam int IRQ = 3;
  localparam logic [5:0] A_PWR = sleep_reset_pkg::OFS_POWER_REDUCTION;
  localparam logic [5:0] A_SLP = sleep_reset_pkg::OFS_SLEEP_MODE;
  localparam logic [5:0] A_SUP = sleep_reset_pkg::OFS_SUPPLY_MON;
  localparam logic [5:0] A_CAUSE = sleep_reset_pkg::OFS_RESET_CAUSE;
  logic sys_clk, nrst, ext_reset_pin_n, external_reset_disable_fuse, supply_below_level;
  logic wdt_timeout, wdt_reset_mode, sleep_instr, wake_event, reg_wr, reg_rd;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd_val;
  logic core_reset, io_port_reset, cpu_clk_en, io_clk_en, timer_clk_en, adc_clk_en, osc_en;
  logic comparator_mux_allowed, adc_reg_access_en, timer_reg_access_en, supply_low_irq;
  logic [2:0] supply_trigger_level;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int n;
  wire logic [3:0] mon;

  assign mon = {supply_low_irq, cpu_clk_en, core_reset, io_port_reset};

  sleep_and_reset_control #(.STARTUP_CYCLES(SU)) i_dut (
    .sys_clk, .nrst, .ext_reset_pin_n, .external_reset_disable_fuse, .supply_below_level,
    .wdt_timeout, .wdt_reset_mode, .sleep_instr, .wake_event, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .core_reset, .io_port_reset, .cpu_clk_en, .io_clk_en,
    .timer_clk_en, .adc_clk_en, .osc_en, .comparator_mux_allowed, .adc_reg_access_en,
    .timer_reg_access_en, .supply_trigger_level, .supply_low_irq
  );

  core_model i_core (
    .sys_clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .sleep_instr,
    .wake_event
  );

  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // verdict and end of run
  task automatic end_sim;
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the scenarios need
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      end_sim;
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    i_core.rd(a, rd_val);
    chk(rd_val, e);
  endtask

  // bounded wait for one watched output, counting edges
  task automatic wait_mon(input int idx, input logic v, input int lim, output int cnt);
    cnt = 0;
    #1;
    while (mon[idx] !== v && cnt < lim) begin
      @(posedge sys_clk);
      #1;
      cnt = cnt + 1;
    end
  endtask

  // power-on reset, entered with nrst already low
  task automatic t_power_on;
    #1;
    chk({core_reset, io_port_reset, cpu_clk_en}, 8'h06);
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    wait_mon(CR, 1'b0, 40, n);
    chk(8'(n >= SU && n <= SU + 6), 8'h01);
    rchk(A_CAUSE, 8'h01);
    rchk(A_PWR, 8'h00);
    rchk(A_SLP, 8'h00);
    rchk(A_SUP, 8'h00);
    rchk(6'h00, 8'h00);
  endtask

  // clock stops: {adc, comparator mux, adc access, timer, timer access}
  task automatic t_prr;
    i_core.stop_converter;
    #1;
    chk({adc_clk_en, comparator_mux_allowed, adc_reg_access_en, timer_clk_en,
         timer_reg_access_en}, 8'h03);
    i_core.wr(A_PWR, 8'h01);
    #1;
    chk({adc_clk_en, comparator_mux_allowed, adc_reg_access_en, timer_clk_en,
         timer_reg_access_en}, 8'h1c);
    rchk(A_PWR, 8'h01);
    i_core.wr(A_PWR, 8'hff);
    rchk(A_PWR, 8'h03);
    i_core.wr(A_PWR, 8'h00);
    #1;
    chk({adc_clk_en, timer_clk_en, timer_reg_access_en}, 8'h07);
  endtask

  // every mode code; expected enables are {io, timer, adc, osc}
  task automatic t_sleep;
    logic [2:0] m;
    logic [3:0] en;
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      en = (i == 0) ? 4'hf : (i == 1) ? 4'h3 : (i == 2) ? 4'h0 : 4'h1;
      i_core.sleep_go(m, 1'b1);
      #1;
      chk(cpu_clk_en, (i == 3 || i > 4));
      if (i != 3 && i < 5) begin
        chk({io_clk_en, timer_clk_en, adc_clk_en, osc_en}, en);
        i_core.wake;
        wait_mon(CPU, 1'b1, 80, n);
        chk(8'(n), (i == 2) ? 8'(sleep_reset_pkg::OSC_START_CYCLES + 4) : 8'h04);
      end
      i_core.disarm;
    end
    i_core.sleep_go(3'h0, 1'b0);
    #1;
    chk(cpu_clk_en, 1'b1);
  endtask

  // watchdog expiry with the reset mode off, then on
  task automatic t_watchdog;
    i_core.wr(A_CAUSE, 8'h00);
    i_core.wr(A_PWR, 8'h03);
    for (int md = 0; md < 2; md++) begin
      @(posedge sys_clk);
      wdt_reset_mode <= md[0];
      @(posedge sys_clk);
      wdt_timeout <= 1'b1;
      @(posedge sys_clk);
      wdt_timeout <= 1'b0;
      wait_mon(CR, 1'b1, 5, n);
      chk(core_reset, md[0]);
    end
    wait_mon(CR, 1'b0, 40, n);
    chk(8'(n >= SU - 1 && n <= SU + 4), 8'h01);
    rchk(A_CAUSE, 8'h08);
    rchk(A_PWR, 8'h00);
    @(posedge sys_clk);
    wdt_reset_mode <= 1'b0;
  endtask

  // external pin, first with the disable fuse set
  task automatic t_ext_pin;
    @(posedge sys_clk);
    external_reset_disable_fuse <= 1'b1;
    repeat (4) @(posedge sys_clk);
    ext_reset_pin_n <= 1'b0;
    #1;
    chk(io_port_reset, 1'b0);
    repeat (6) @(posedge sys_clk);
    #1;
    chk(core_reset, 1'b0);
    @(posedge sys_clk);
    ext_reset_pin_n <= 1'b1;
    external_reset_disable_fuse <= 1'b0;
    i_core.wr(A_CAUSE, 8'h00);
    repeat (3) @(posedge sys_clk);
    ext_reset_pin_n <= 1'b0;
    #1;
    chk(io_port_reset, 1'b1);
    wait_mon(CR, 1'b1, 6, n);
    repeat (20) @(posedge sys_clk);
    #1;
    chk(core_reset, 1'b1);
    @(posedge sys_clk);
    ext_reset_pin_n <= 1'b1;
    wait_mon(CR, 1'b0, 40, n);
    chk(8'(n >= SU && n <= SU + 6), 8'h01);
    rchk(A_CAUSE, 8'h02);
  endtask

  // supply monitor: flag, interrupt, clears, then reset mode
  task automatic t_supply;
    i_core.wr(A_SUP, 8'h0d);
    #1;
    chk(supply_trigger_level, 8'h05);
    @(posedge sys_clk);
    for (int k = 0; k < 2; k++) begin
      supply_below_level <= 1'b1;
      wait_mon(IRQ, 1'b1, 8, n);
      chk(supply_low_irq, 1'b1);
      if (k == 0) begin
        rchk(A_SUP, 8'h8d);
        i_core.wr(A_SUP, 8'h0d);
        #1;
        chk(supply_low_irq, 1'b0);
      end else begin
        i_core.wr(A_SUP, 8'h0c);
        rchk(A_SUP, 8'h0c);
      end
      @(posedge sys_clk);
      supply_below_level <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    supply_below_level <= 1'b1;
    wait_mon(IRQ, 1'b1, 8, n);
    @(posedge sys_clk);
    supply_below_level <= 1'b0;
    wait_mon(IRQ, 1'b0, 8, n);
    chk(supply_low_irq, 1'b0);
    i_core.wr(A_SUP, 8'h14);
    i_core.wr(A_CAUSE, 8'h00);
    supply_below_level <= 1'b1;
    wait_mon(CR, 1'b1, 6, n);
    repeat (20) @(posedge sys_clk);
    #1;
    chk({core_reset, supply_low_irq}, 8'h02);
    @(posedge sys_clk);
    supply_below_level <= 1'b0;
    wait_mon(CR, 1'b0, 40, n);
    chk(8'(n >= SU && n <= SU + 6), 8'h01);
    rchk(A_CAUSE, 8'h04);
  endtask

  // main sequence
  initial begin
    nrst = 1'b0;
    ext_reset_pin_n = 1'b1;
    external_reset_disable_fuse = 1'b0;
    supply_below_level = 1'b0;
    wdt_timeout = 1'b0;
    wdt_reset_mode = 1'b0;
    t_power_on;
    t_prr;
    t_sleep;
    t_watchdog;
    t_ext_pin;
    t_supply;
    @(posedge sys_clk);
    nrst <= 1'b0;
    t_power_on;
    end_sim;
  end
endmodule
